// [hw/crc32_calc_unit.sv]
// crc-32 calculation unit with axi4-lite register access
//
// Implementation choice: register access over AXI4-Lite.

// Behaviour
// - fixed ethernet crc-32 polynomial, not programmable
// - one word folded within four clock cycles
// - whole 32-bit word folded into running crc
// - write response held until folding completes
// - data register read returns latest crc
// - control bit 0 reloads all ones, self-clears
// - 8-bit scratch survives calculator reset
module crc32_calc_unit #(
  parameter int ADDR_W = 4
) (
  // clock, reset, clock enable
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // write address channel
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  // write data channel
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // write response channel
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // read address channel
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  // read data channel
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);

  // overview of the datapath
  // a data write is caught on the bus, parked in the word fifo,
  // drawn into the engine and folded a byte per clock
  // the engine needs four clocks per word, one per byte lane
  // the write response waits for the fold, so software never
  // reads a stale result right after a write
  // scratch and control writes answer at once
  // the control reset bit is a pulse and is never stored
  // reading the control register always returns zero
  // unmapped offsets answer with a slave error on both sides
  // one write and one read may be under way at a time
  // reads of the data register wait while a word is in flight
  // all outputs are fields of the single state register
  // the fifo is deeper than needed; at most one word sits in it
  // trade-off: byte-serial folding keeps the xor tree small
  // at the cost of a few clocks of write latency
  // limitation: byte strobes are ignored for data words

  // complete state of the unit, registered as one word
  typedef struct packed {
    // write side
    crc32_pkg::wr_state_t wr_state;
    logic                 aw_held;
    logic [3:0]           aw_off;
    logic                 w_held;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    // read side
    logic                 ar_held;
    logic [3:0]           ar_off;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    // calculator
    logic [31:0]          crc;
    logic [7:0]           scratch;
    logic                 busy;
    logic [1:0]           step;
    logic [31:0]          word;
  } unit_state_t;

  unit_state_t s_reg;
  unit_state_t s_next;

  // fifo hookup
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [31:0] fifo_out_data;
  logic        fifo_empty;
  logic        crc_pending;

  // fold one byte, msb first, into the running crc
  function automatic logic [31:0] fold_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (r[31] ^ b[i])
        r = {r[30:0], 1'b0} ^ crc32_pkg::CRC_POLY;
      else
        r = {r[30:0], 1'b0};
    end
    return r;
  endfunction

  // the write path queues data words; the fifo never holds more than one
  // word here because the response waits, but its ready still stalls us
  crc_word_fifo #(
    .WIDTH (32),
    .DEPTH (crc32_pkg::FIFO_WORDS)
  ) word_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (s_reg.w_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .empty     (fifo_empty)
  );

  assign fifo_in_valid  = (s_reg.wr_state == crc32_pkg::WR_PUSH);
  assign fifo_out_ready = !s_reg.busy;
  // a word is somewhere between the bus and the crc register
  assign crc_pending    = fifo_in_valid || (s_reg.wr_state == crc32_pkg::WR_WAIT)
                          || !fifo_empty || s_reg.busy;

  // outputs come straight from the state register
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready  = s_reg.wready;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;

  // all next-state logic
  // order inside this process matters:
  // captures first, then the engine, then the write phases,
  // then the read side, and the readies last
  // the readies are derived from the next held flags so that
  // a capture drops its ready on the following clock
  // and a released capture raises it again on the same clock as its held flag clears
  // the engine runs whether or not a write is waiting,
  // so the fifo drains even while the response is stalled
  always_comb
  begin
    s_next = s_reg;

    // address and data are caught independently, in either order
    if (s_axi_awvalid && s_reg.awready)
    begin
      s_next.aw_held = 1'b1;
      s_next.aw_off  = 4'(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_reg.wready)
    begin
      s_next.w_held = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end

    // crc engine: one byte per cycle, four cycles per word
    if (s_reg.busy)
    begin
      s_next.crc  = fold_byte(s_reg.crc, s_reg.word[31:24]);
      s_next.word = {s_reg.word[23:0], 8'h00};
      s_next.step = s_reg.step + 1'b1;
      if (s_reg.step == crc32_pkg::CRC_LAST_STEP)
        s_next.busy = 1'b0;
    end
    else if (fifo_out_valid)
    begin
      s_next.busy = 1'b1;
      s_next.step = 2'h0;
      s_next.word = fifo_out_data;
    end

    // write channel phases
    // idle: wait until both halves of the write are held
    // push: hand the data word to the fifo
    // wait: hold the response until the engine is idle
    // resp: hold the response until the master takes it
    // register writes skip push and wait entirely
    // the held flags clear on leaving idle for register writes or push for data,
    // which reopens the address and data channels
    case (s_reg.wr_state)
      crc32_pkg::WR_IDLE:
      begin
        if (s_reg.aw_held && s_reg.w_held)
        begin
          s_next.bresp = crc32_pkg::RESP_OKAY;
          case (s_reg.aw_off)
            crc32_pkg::OFF_DATA:
              s_next.wr_state = crc32_pkg::WR_PUSH;
            crc32_pkg::OFF_SCRATCH:
            begin
              // only lane 0 carries storage; upper bits are not kept
              if (s_reg.w_strb[0])
                s_next.scratch = s_reg.w_data[7:0];
            end
            crc32_pkg::OFF_CONTROL:
            begin
              // the reset bit is a pulse, nothing is stored for it
              if (s_reg.w_data[crc32_pkg::CTRL_RESET_BIT] && s_reg.w_strb[0])
                s_next.crc = crc32_pkg::CRC_INIT;
            end
            default:
              s_next.bresp = crc32_pkg::RESP_SLVERR;
          endcase
          if (s_reg.aw_off != crc32_pkg::OFF_DATA)
          begin
            s_next.aw_held  = 1'b0;
            s_next.w_held   = 1'b0;
            s_next.bvalid   = 1'b1;
            s_next.wr_state = crc32_pkg::WR_RESP;
          end
        end
      end
      crc32_pkg::WR_PUSH:
      begin
        if (fifo_in_ready)
        begin
          s_next.aw_held  = 1'b0;
          s_next.w_held   = 1'b0;
          s_next.wr_state = crc32_pkg::WR_WAIT;
        end
      end
      crc32_pkg::WR_WAIT:
      begin
        // response stalls until the word has been folded in
        if (fifo_empty && !s_reg.busy && !fifo_out_valid)
        begin
          s_next.bvalid   = 1'b1;
          s_next.wr_state = crc32_pkg::WR_RESP;
        end
      end
      crc32_pkg::WR_RESP:
      begin
        if (s_axi_bready)
        begin
          s_next.bvalid   = 1'b0;
          s_next.wr_state = crc32_pkg::WR_IDLE;
        end
      end
      default:
        s_next.wr_state = crc32_pkg::WR_IDLE;
    endcase

    // read channel
    // an address is held until the answer can be formed
    // the answer stands until the master raises rready
    // a data read during a fold waits, so the value is fresh
    // other offsets answer on the second clock after the capture
    if (s_axi_arvalid && s_reg.arready)
    begin
      s_next.ar_held = 1'b1;
      s_next.ar_off  = 4'(s_axi_araddr);
    end
    if (s_reg.rvalid)
    begin
      if (s_axi_rready)
        s_next.rvalid = 1'b0;
    end
    else if (s_reg.ar_held)
    begin
      // a crc read waits for any word still in flight
      if (!(s_reg.ar_off == crc32_pkg::OFF_DATA && crc_pending))
      begin
        s_next.ar_held = 1'b0;
        s_next.rvalid  = 1'b1;
        s_next.rresp   = crc32_pkg::RESP_OKAY;
        case (s_reg.ar_off)
          crc32_pkg::OFF_DATA:
            s_next.rdata = s_reg.crc;
          crc32_pkg::OFF_SCRATCH:
            s_next.rdata = {24'h000000, s_reg.scratch};
          crc32_pkg::OFF_CONTROL:
            s_next.rdata = crc32_pkg::READ_ZERO;
          default:
          begin
            s_next.rdata = crc32_pkg::READ_ZERO;
            s_next.rresp = crc32_pkg::RESP_SLVERR;
          end
        endcase
      end
    end

    // readies are registered, so they drop the cycle after a capture
    s_next.awready = !s_next.aw_held;
    s_next.wready  = !s_next.w_held;
    s_next.arready = !s_next.ar_held;
  end

  // single state register, frozen while the clock enable is low
  // reset loads only constants: idle phases, crc all ones,
  // scratch cleared and every ready low until the first clock
  // the fifo shares this reset and enable, so both stay aligned
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg          <= '0;
      s_reg.wr_state <= crc32_pkg::WR_IDLE;
      s_reg.crc      <= crc32_pkg::CRC_INIT;
      s_reg.scratch  <= crc32_pkg::SCRATCH_RESET;
    end
    else if (ce)
    begin
      s_reg <= s_next;
    end
  end

endmodule

// [hw/crc32_pkg.sv]
// constants shared by the crc calculation unit and its word fifo
package crc32_pkg;

  // register byte offsets on the register bus
  localparam logic [3:0] OFF_DATA    = 4'h0;
  localparam logic [3:0] OFF_SCRATCH = 4'h4;
  localparam logic [3:0] OFF_CONTROL = 4'h8;

  // field positions and values after reset
  localparam int          CTRL_RESET_BIT = 0;
  localparam logic [31:0] CRC_INIT       = 32'hffffffff;
  localparam logic [7:0]  SCRATCH_RESET  = 8'h00;
  localparam logic [31:0] READ_ZERO      = 32'h00000000;

  // fixed generator polynomial, ethernet crc-32, normal form
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;

  // one word is folded a byte per cycle
  localparam logic [1:0] CRC_LAST_STEP = 2'h3;

  // fifo in the data path
  localparam int FIFO_WORDS = 32;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // write channel phases
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_PUSH = 2'b01,
    WR_WAIT = 2'b10,
    WR_RESP = 2'b11
  } wr_state_t;

endpackage

// [hw/crc_word_fifo.sv]
// word fifo with registered read data between bus writes and the crc engine
module crc_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = crc32_pkg::FIFO_WORDS
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // nothing stored anywhere
  output logic                  empty
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wptr;
    logic [PW-1:0]               rptr;
    logic [PW:0]                 count;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } fifo_state_t;

  fifo_state_t s_reg;
  fifo_state_t s_next;
  logic        push;
  logic        load;

  // depth must be a power of two so the pointers wrap by themselves
  assign in_ready  = s_reg.count < (PW+1)'(DEPTH);
  assign out_valid = s_reg.out_valid;
  assign out_data  = s_reg.out_data;
  assign empty     = (s_reg.count == '0) && !s_reg.out_valid;
  assign push      = in_valid && in_ready;
  assign load      = (s_reg.count != '0) && (!s_reg.out_valid || out_ready);

  // storage, pointers and the output register
  always_comb
  begin
    s_next = s_reg;
    if (push)
    begin
      s_next.mem[s_reg.wptr] = in_data;
      s_next.wptr            = s_reg.wptr + 1'b1;
    end
    if (load)
    begin
      s_next.out_data  = s_reg.mem[s_reg.rptr];
      s_next.out_valid = 1'b1;
      s_next.rptr      = s_reg.rptr + 1'b1;
    end
    else if (out_ready)
    begin
      s_next.out_valid = 1'b0;
    end
    case ({push, load})
      2'b10:   s_next.count = s_reg.count + 1'b1;
      2'b01:   s_next.count = s_reg.count - 1'b1;
      default: s_next.count = s_reg.count;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_reg <= '0;
    else if (ce)
      s_reg <= s_next;
  end

endmodule

// [sim/crc32_calc_unit_assertions.sv]
// bus-side checks for the crc unit
module crc32_calc_unit_checker #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // write side
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  // read side
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ADDR_W-1:0] rd_addr;
  logic              aw_w;
  logic              mapped;

  // offset of the read under way, so answers can be judged
  always_ff @(posedge clk or posedge rst)
    if (rst)
      rd_addr <= '0;
    else if (s_axi_arvalid && s_axi_arready)
      rd_addr <= s_axi_araddr;

  // both halves of a write taken together, as the host model does
  assign aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign mapped = rd_addr == 4'h0 || rd_addr == 4'h4 || rd_addr == 4'h8;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_fold_time;
    aw_w && s_axi_awaddr == crc32_pkg::OFF_DATA |=>
      !s_axi_bvalid [*8] ##1 !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_fold_time: assert property (p_fold_time) else $error("fold time wrong");
  property p_reg_time;
    aw_w && s_axi_awaddr != crc32_pkg::OFF_DATA |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_reg_time: assert property (p_reg_time) else $error("reg write time wrong");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_time;
    s_axi_arvalid && s_axi_arready && s_axi_araddr != 4'h0 |=> !s_axi_rvalid ##1 s_axi_rvalid;
  endproperty
  a_rd_time: assert property (p_rd_time) else $error("read time wrong");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_rresp;
    s_axi_rvalid |-> s_axi_rresp == (mapped ? 2'h0 : 2'h2);
  endproperty
  a_rresp: assert property (p_rresp) else $error("read response wrong");
  property p_ctrl_zero;
    s_axi_rvalid && rd_addr == crc32_pkg::OFF_CONTROL |-> s_axi_rdata == 32'h00000000;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("control bit stuck");
  property p_scr_upper;
    s_axi_rvalid && rd_addr == crc32_pkg::OFF_SCRATCH |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_scr_upper: assert property (p_scr_upper) else $error("scratch upper bits set");
endmodule

// [sim/axi_lite_host.sv]
// bus master model standing in for the processor
module axi_lite_host (
  // clock
  input wire logic  clk,
  // write channels
  output logic        s_axi_awvalid,
  input wire logic    s_axi_awready,
  output logic [3:0]  s_axi_awaddr,
  output logic        s_axi_wvalid,
  input wire logic    s_axi_wready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  input wire logic    s_axi_bvalid,
  output logic        s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // read channels
  output logic        s_axi_arvalid,
  input wire logic    s_axi_arready,
  output logic [3:0]  s_axi_araddr,
  input wire logic    s_axi_rvalid,
  output logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  int lag = 0;

  // idle bus at time zero
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hf;
  end

  // one word write; released lines show the inverse, not stale data
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_do;
    logic w_do;
    aw_do = 1'b1;
    w_do = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // local flags: the valid lines themselves update only after this step
    do
    begin
      @(posedge clk);
      if (aw_do && s_axi_awready)
      begin
        aw_do = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (w_do && s_axi_wready)
      begin
        w_do = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    while (aw_do || w_do);
    repeat (lag) @(posedge clk);
    s_axi_bready <= 1'b1;
    do
      @(posedge clk);
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // one word read, ready held back by lag cycles
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
      @(posedge clk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    repeat (lag) @(posedge clk);
    s_axi_rready <= 1'b1;
    do
      @(posedge clk);
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// [sim/crc32_calc_unit_tb.sv]
// self-checking bench for the crc unit
module crc32_calc_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, exp_crc, got;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] words [4] = '{32'h12345678, 32'hffffffff, 32'h00000001, 32'ha5a5a5a5};
  int          miscompares = 0;
  int          checked = 0;

  // 40 mhz clock
  always #12.5 clk = ~clk;

  crc32_calc_unit #(.ADDR_W(4)) u_dut (.*);
  axi_lite_host u_host (.*);

  // msb-first fold of a whole word, no reflection
  function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
      c = (c[31] ^ w[i]) ? ((c << 1) ^ crc32_pkg::CRC_POLY) : (c << 1);
    return c;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    u_host.rd(4'h0, got, resp);
    chk(got, 32'hffffffff);
    u_host.rd(4'h4, got, resp);
    chk(got, 32'h00000000);
    u_host.rd(4'h8, got, resp);
    chk(got, 32'h00000000);
    $display("test reset values done");
    u_host.wr(4'h0, 32'h00000000, resp);
    u_host.rd(4'h0, got, resp);
    chk(got, 32'hc704dd7b);
    exp_crc = 32'hc704dd7b;
    // back-to-back writes, ready lag of i cycles on word i, crc read back after odd words
    for (int i = 0; i < 4; i++)
    begin
      u_host.lag = i;
      u_host.wr(4'h0, words[i], resp);
      chk({30'h0, resp}, 32'h0);
      exp_crc = fold(exp_crc, words[i]);
      if (i[0])
      begin
        u_host.rd(4'h0, got, resp);
        chk(got, exp_crc);
      end
    end
    $display("test fold done");
    u_host.wr(4'h4, 32'h000000a5, resp);
    u_host.wr(4'h8, 32'h00000000, resp);
    u_host.rd(4'h0, got, resp);
    chk(got, exp_crc);
    u_host.wr(4'h8, 32'h00000001, resp);
    u_host.rd(4'h0, got, resp);
    chk(got, 32'hffffffff);
    u_host.rd(4'h4, got, resp);
    chk(got, 32'h000000a5);
    u_host.rd(4'h8, got, resp);
    chk(got, 32'h00000000);
    $display("test control done");
    u_host.wr(4'hc, 32'h00000001, resp);
    chk({30'h0, resp}, 32'h2);
    u_host.rd(4'hc, got, resp);
    chk({30'h0, resp}, 32'h2);
    $display("test unmapped done");
    finish_test();
  end

  // watchdog, far beyond the hundred or so cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule

bind crc32_calc_unit crc32_calc_unit_checker #(.ADDR_W(ADDR_W)) u_chk (.*);
